// File: include/bepc_pkg.sv
// Package for the bus event performance counter: event codes, masks, widths.
// Assumes one 100 MHz core clock; bus-clock cycles arrive as an enable pulse.
// Contract
// - Event code 6e counts completed burst transactions, unit mask 00 for self only and 20 for any agent.
// - Event code 70 counts every completed bus transaction including special cycles, self or any agent.
// - Event code 6f counts completed memory transactions, self or any agent.
// - Event code 64 counts bus clock cycles in which this device receives data, self mask only.
// - Event code 61 counts bus clock cycles in which this device drives block-next-request active.
// - Event code 7a counts bus clock cycles in which this device drives the snoop-hit pin.
// - Event code 7b counts bus clock cycles in which this device drives the snoop-hit-modified pin.
// - The snoop-hit pin-drive counts include cycles driven because of snoop stalls.
// - The snoop-hit pin-drive counts are correct whatever the pin-control bit or clock ratio.
// - With ratio 2:1 or 3:1 and pin control set, the monitor pins pulse for one clock on overflow.
// - With pin control clear, the monitor pins toggle on each overflow.
// - With any other ratio the monitor pins stay silent for the snoop-hit pin-drive events.
`default_nettype none
package bepc_pkg;
  localparam logic [7:0] EVT_BURST = 8'h6e;
  localparam logic [7:0] EVT_MEM = 8'h6f;
  localparam logic [7:0] EVT_ANY = 8'h70;
  localparam logic [7:0] EVT_DATA_RCV = 8'h64;
  localparam logic [7:0] EVT_BNR_DRV = 8'h61;
  localparam logic [7:0] EVT_HIT_DRV = 8'h7a;
  localparam logic [7:0] EVT_SNOOP_HIT_MODIFIED_N_DRV = 8'h7b;
  localparam logic [7:0] UMASK_SELF = 8'h00;
  localparam logic [7:0] UMASK_ANY = 8'h20;
  localparam int PIN_CONTROL_BIT = 19;
  localparam int CNT_WIDTH = 40;
  localparam logic [1:0] RATIO_2TO1 = 2'h2;
  localparam logic [1:0] RATIO_3TO1 = 2'h3;

  // One bus clock of observed activity, sampled on the bus-clock enable
  typedef struct packed {
    logic tran_done;      // A transaction completed this bus clock
    logic tran_self;      // It was issued by this device
    logic tran_burst;
    logic tran_mem;
    logic data_rcv;       // This device received data
    logic bnr_drv;        // This device drives block_next_request_n
    logic hit_drv;        // Snoop-hit driven, snoop stalls included
    logic snoop_hit_modified_n_drv;       // snoop_hit_modified_n driven, stalls included
  } bepc_bus_evt_t;

  typedef struct packed {
    logic [7:0] evt_code;
    logic [7:0] unit_mask;
    logic pin_control_bit;
    logic enable;
  } bepc_sel_t;
endpackage
`default_nettype wire

// File: design/bepc_counter.sv
// Wrapping event counter with an overflow pulse.
// Assumes the increment request is a one-cycle level per event.
`default_nettype none
module bepc_counter #(
  parameter int WIDTH = 40
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Control
  input wire logic i_clear,
  input wire logic i_inc,
  // Result
  output logic [WIDTH-1:0] o_count,
  output logic o_ovf
);
  wire logic wrap = i_inc && (&o_count);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_count <= '0;
      o_ovf <= 1'b0;
    end else if (i_clear) begin
      o_count <= '0;
      o_ovf <= 1'b0;
    end else begin
      o_count <= o_count + WIDTH'(i_inc);
      o_ovf <= wrap;
    end
  end

  AST_WRAP_FLAG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!i_clear && i_inc && (&o_count)) |=> (o_ovf && o_count == '0))
    else $error("Counter wrap did not flag overflow");
  AST_STEP_ONE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!i_clear && i_inc && !(&o_count)) |=> (o_count == $past(o_count) + 1'b1 && !o_ovf))
    else $error("Counter did not step by one");
endmodule
`default_nettype wire

// File: design/bepc_top.sv
// Bus event selection, counting and breakpoint-monitor overflow signalling.
// Assumes bus activity flags are valid in cycles where i_bus_clk_en is high.
`default_nettype none
module bepc_top #(
  parameter int CNT_W = bepc_pkg::CNT_WIDTH
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Bus activity
  input wire logic i_bus_clk_en,
  input wire bepc_pkg::bepc_bus_evt_t i_bus_evt,
  // Configuration
  input wire bepc_pkg::bepc_sel_t i_sel,
  input wire logic [1:0] i_clk_ratio,
  input wire logic i_count_clear,
  // Results
  output logic [CNT_W-1:0] o_count,
  output logic o_overflow,
  output logic o_breakpoint_monitor_pins
);
  import bepc_pkg::*;

  wire logic any_mask = (i_sel.unit_mask == UMASK_ANY);
  wire logic self_mask = (i_sel.unit_mask == UMASK_SELF);
  // Any-agent counting takes every completion; self only its own
  wire logic agent_ok = any_mask || (self_mask && i_bus_evt.tran_self);
  wire logic done_ok = i_bus_clk_en && i_bus_evt.tran_done && agent_ok;
  wire logic is_hit_evt = (i_sel.evt_code == EVT_HIT_DRV) || (i_sel.evt_code == EVT_SNOOP_HIT_MODIFIED_N_DRV);
  wire logic ratio_ok = (i_clk_ratio == RATIO_2TO1) || (i_clk_ratio == RATIO_3TO1);
  // One wire per event code keeps the selection flat and easy to probe
  wire logic code_burst = (i_sel.evt_code == EVT_BURST);
  wire logic code_mem = (i_sel.evt_code == EVT_MEM);
  wire logic code_any = (i_sel.evt_code == EVT_ANY);
  wire logic code_rcv = (i_sel.evt_code == EVT_DATA_RCV);
  wire logic code_bnr = (i_sel.evt_code == EVT_BNR_DRV);
  wire logic code_hit = (i_sel.evt_code == EVT_HIT_DRV);
  wire logic code_snoop_hit_modified_n = (i_sel.evt_code == EVT_SNOOP_HIT_MODIFIED_N_DRV);
  wire logic cnt_burst = code_burst && done_ok && i_bus_evt.tran_burst;
  wire logic cnt_any = code_any && done_ok;
  wire logic cnt_mem = code_mem && done_ok && i_bus_evt.tran_mem;
  wire logic cnt_rcv = code_rcv && i_bus_clk_en && self_mask && i_bus_evt.data_rcv;
  wire logic cnt_bnr = code_bnr && i_bus_clk_en && i_bus_evt.bnr_drv;
  // Stall-driven cycles already show in the drive flags; no gating by ratio
  wire logic cnt_hit = code_hit && i_bus_clk_en && i_bus_evt.hit_drv;
  wire logic cnt_snoop_hit_modified_n = code_snoop_hit_modified_n && i_bus_clk_en && i_bus_evt.snoop_hit_modified_n_drv;
  // Codes are exclusive, so at most one term is live in a cycle
  wire logic hit_sel = cnt_burst || cnt_any || cnt_mem || cnt_rcv || cnt_bnr || cnt_hit || cnt_snoop_hit_modified_n;
  wire logic evt_hit = hit_sel && i_sel.enable;

  logic ovf;
  bepc_counter #(.WIDTH(CNT_W)) u_cnt (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_clear(i_count_clear),
    .i_inc(evt_hit),
    .o_count(o_count),
    .o_ovf(ovf)
  );
  assign o_overflow = ovf;

  // Pin behaviour for the snoop-hit events depends on ratio; others follow pin control only
  wire logic pins_live = !is_hit_evt || ratio_ok;
  logic bpm_q;
  logic bpm_d;
  always_comb begin
    bpm_d = bpm_q;
    if (!pins_live) begin
      bpm_d = 1'b0;
    end else if (i_sel.pin_control_bit) begin
      bpm_d = ovf;
    end else if (ovf) begin
      bpm_d = !bpm_q;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bpm_q <= 1'b0;
    end else begin
      bpm_q <= bpm_d;
    end
  end
  assign o_breakpoint_monitor_pins = bpm_q;

  // Transaction events: agent qualification by unit mask
  AST_BURST_SELF: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && i_sel.evt_code == EVT_BURST && i_sel.unit_mask == UMASK_SELF && i_bus_clk_en
     && i_bus_evt.tran_done && i_bus_evt.tran_burst && !i_bus_evt.tran_self) |-> !evt_hit)
    else $error("Foreign burst counted under self mask");
  AST_BURST_ANY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && code_burst && any_mask && i_bus_clk_en
     && i_bus_evt.tran_done && i_bus_evt.tran_burst) |-> evt_hit)
    else $error("Burst from any agent not counted");
  AST_BURST_OWN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && code_burst && self_mask && i_bus_clk_en
     && i_bus_evt.tran_done && i_bus_evt.tran_burst && i_bus_evt.tran_self) |-> evt_hit)
    else $error("Own burst not counted");
  AST_BURST_NEED: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (code_burst && evt_hit) |-> (i_bus_evt.tran_burst && i_bus_evt.tran_done && i_bus_clk_en))
    else $error("Burst count without burst completion");
  AST_ANY_TRAN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && i_sel.evt_code == EVT_ANY && i_sel.unit_mask == UMASK_ANY && i_bus_clk_en
     && i_bus_evt.tran_done) |-> evt_hit)
    else $error("Completed transaction not counted");
  AST_ANY_SELF_OWN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && code_any && self_mask && i_bus_clk_en
     && i_bus_evt.tran_done && i_bus_evt.tran_self) |-> evt_hit)
    else $error("Own transaction not counted");
  AST_ANY_SELF_FOREIGN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (code_any && self_mask && !i_bus_evt.tran_self) |-> !evt_hit)
    else $error("Foreign transaction counted under self mask");
  AST_ANY_NEED: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (code_any && evt_hit) |-> (i_bus_evt.tran_done && i_bus_clk_en))
    else $error("Transaction count without completion");
  AST_MEM_TRAN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.evt_code == EVT_MEM && evt_hit) |-> (i_bus_evt.tran_mem && i_bus_evt.tran_done))
    else $error("Memory count without memory completion");
  AST_MEM_ANY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && code_mem && any_mask && i_bus_clk_en
     && i_bus_evt.tran_done && i_bus_evt.tran_mem) |-> evt_hit)
    else $error("Memory transaction from any agent not counted");
  AST_MEM_OWN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && code_mem && self_mask && i_bus_clk_en
     && i_bus_evt.tran_done && i_bus_evt.tran_mem && i_bus_evt.tran_self) |-> evt_hit)
    else $error("Own memory transaction not counted");
  AST_MEM_SELF_FOREIGN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (code_mem && self_mask && !i_bus_evt.tran_self) |-> !evt_hit)
    else $error("Foreign memory transaction counted under self mask");
  AST_BAD_MASK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ((code_burst || code_mem || code_any) && !any_mask && !self_mask) |-> !evt_hit)
    else $error("Transaction counted under unknown unit mask");

  // Pin-drive and receive events
  AST_DATA_RCV: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.evt_code == EVT_DATA_RCV && evt_hit) |-> (i_bus_evt.data_rcv && i_bus_clk_en))
    else $error("Receive count without received data");
  AST_DATA_MASK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (code_rcv && !self_mask) |-> !evt_hit)
    else $error("Receive cycle counted under foreign mask");
  AST_DATA_COUNT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && code_rcv && self_mask && i_bus_clk_en && i_bus_evt.data_rcv) |-> evt_hit)
    else $error("Receive cycle missed");
  AST_BNR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && i_sel.evt_code == EVT_BNR_DRV && i_bus_clk_en) |-> (evt_hit == i_bus_evt.bnr_drv))
    else $error("Block-next drive count wrong");
  AST_HIT_ANY_RATIO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && i_sel.evt_code == EVT_HIT_DRV && i_bus_clk_en && i_bus_evt.hit_drv) |-> evt_hit)
    else $error("Snoop-hit drive cycle missed");
  AST_HIT_ONLY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (code_hit && evt_hit) |-> (i_bus_evt.hit_drv && i_bus_clk_en))
    else $error("Snoop-hit count without drive");
  AST_SNOOP_HIT_MODIFIED_N: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && i_sel.evt_code == EVT_SNOOP_HIT_MODIFIED_N_DRV && i_bus_clk_en && i_bus_evt.snoop_hit_modified_n_drv) |-> evt_hit)
    else $error("Snoop-hit-modified drive cycle missed");
  AST_SNOOP_HIT_MODIFIED_N_ONLY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (code_snoop_hit_modified_n && evt_hit) |-> (i_bus_evt.snoop_hit_modified_n_drv && i_bus_clk_en))
    else $error("Snoop-hit-modified count without drive");
  AST_HIT_RATIO_FREE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.enable && i_bus_clk_en && !ratio_ok
     && ((code_hit && i_bus_evt.hit_drv) || (code_snoop_hit_modified_n && i_bus_evt.snoop_hit_modified_n_drv))) |-> evt_hit)
    else $error("Snoop drive cycle missed at other ratio");

  // Counting qualifiers
  AST_NO_ENABLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_sel.enable |-> !evt_hit)
    else $error("Event counted while disabled");
  AST_NO_BUS_CLK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_bus_clk_en |-> !evt_hit)
    else $error("Event counted outside a bus clock");
  AST_UNKNOWN_CODE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(code_burst || code_mem || code_any || code_rcv || code_bnr || code_hit || code_snoop_hit_modified_n) |-> !evt_hit)
    else $error("Unknown event code counted");
  AST_COUNT_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!evt_hit && !i_count_clear) |=> $stable(o_count))
    else $error("Count moved without an event");
  AST_COUNT_STEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (evt_hit && !i_count_clear && !(&o_count)) |=> (o_count == $past(o_count) + 1'b1))
    else $error("Count did not step on an event");
  AST_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_count_clear |=> (o_count == '0 && !o_overflow))
    else $error("Clear did not empty the counter");
  AST_OVF_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_overflow |-> (o_count == '0))
    else $error("Overflow flag without wrapped count");
  AST_OVF_SINGLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_overflow |=> !o_overflow)
    else $error("Overflow flag longer than one clock");

  // Breakpoint-monitor pin signalling
  AST_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (ovf && i_sel.pin_control_bit && pins_live) |=> (bpm_q ##1 (!bpm_q || $past(ovf))))
    else $error("Monitor pin pulse not one clock");
  AST_PIN_FOLLOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sel.pin_control_bit && pins_live) |=> (bpm_q == $past(ovf)))
    else $error("Monitor pin does not follow overflow");
  AST_TOGGLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (ovf && !i_sel.pin_control_bit && pins_live) |=> (bpm_q != $past(bpm_q)))
    else $error("Monitor pin did not toggle");
  AST_PIN_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!ovf && !i_sel.pin_control_bit && pins_live) |=> $stable(bpm_q))
    else $error("Monitor pin moved without overflow");
  AST_SILENT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (is_hit_evt && !ratio_ok) |=> !bpm_q)
    else $error("Monitor pin active at unsupported ratio");

  COV_OVF_PULSE: cover property (@(posedge i_clk_sys) disable iff (i_rst) ovf && i_sel.pin_control_bit);
  COV_OVF_TOGGLE: cover property (@(posedge i_clk_sys) disable iff (i_rst) ovf && !i_sel.pin_control_bit);
  COV_HIT_COUNT: cover property (@(posedge i_clk_sys) disable iff (i_rst) evt_hit && is_hit_evt);
  COV_BURST_ANY: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    evt_hit && i_sel.evt_code == EVT_BURST && !i_bus_evt.tran_self);
  // The count must still run while the pins are held silent
  COV_SILENT_OVF: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    ovf && is_hit_evt && !ratio_ok);
endmodule
`default_nettype wire

// File: verification/bepc_bus_model.sv
// Far-side bus model: bus-clock enable pulses and random activity flags.
// Assumes the bench seeds the random source once before traffic matters.
`default_nettype none
module bepc_bus_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Ratio
  input wire logic [1:0] i_clk_ratio,
  // Bus activity
  output logic o_bus_clk_en = 1'b0,
  output bepc_pkg::bepc_bus_evt_t o_bus_evt = '0
);
  timeunit 1ns;
  timeprecision 100ps;
  import bepc_pkg::*;
  int phase = 0;
  // Flags change every cycle, so stale values outside bus clocks never look valid
  always @(posedge i_clk_sys) begin
    #1;
    phase = (i_rst || phase + 1 >= ((i_clk_ratio < 2'h2) ? 1 : int'(i_clk_ratio))) ? 0 : phase + 1;
    o_bus_clk_en = !i_rst && phase == 0;
    o_bus_evt = 8'($urandom);
  end
endmodule
`default_nettype wire

// File: verification/bepc_top_tb.sv
// Bench for the bus event counter: every event code, random traffic, wraps.
// Assumes the bus model drives activity; a 4-bit counter reaches overflow quickly.
`default_nettype none
module bepc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bepc_pkg::*;
  localparam int W = 4;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_count_clear = 1'b0, i_bus_clk_en, o_overflow, o_pins, exp_ovf, exp_pins;
  logic [1:0] i_clk_ratio = 2'h2;
  bepc_sel_t i_sel = '0;
  bepc_bus_evt_t i_bus_evt;
  logic [W-1:0] o_count, exp_cnt;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] codes [12] = '{EVT_BURST, EVT_BURST, EVT_MEM, EVT_MEM, EVT_ANY, EVT_ANY, EVT_DATA_RCV, EVT_BNR_DRV,
    EVT_HIT_DRV, EVT_SNOOP_HIT_MODIFIED_N_DRV, EVT_DATA_RCV, 8'h55};
  logic [7:0] masks [12] = '{8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
  always #5 i_clk_sys = ~i_clk_sys;
  bepc_bus_model bepc_bus_model_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_ratio(i_clk_ratio),
    .o_bus_clk_en(i_bus_clk_en), .o_bus_evt(i_bus_evt));
  bepc_top #(.CNT_W(W)) bepc_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bus_clk_en(i_bus_clk_en),
    .i_bus_evt(i_bus_evt), .i_sel(i_sel), .i_clk_ratio(i_clk_ratio), .i_count_clear(i_count_clear),
    .o_count(o_count), .o_overflow(o_overflow), .o_breakpoint_monitor_pins(o_pins));
  function automatic logic qual(bepc_sel_t s, bepc_bus_evt_t e);
    logic self_m;
    logic who;
    self_m = s.unit_mask === UMASK_SELF;
    who = e.tran_done && (s.unit_mask === UMASK_ANY || (self_m && e.tran_self));
    case (s.evt_code)
      EVT_BURST: return who && e.tran_burst;
      EVT_MEM: return who && e.tran_mem;
      EVT_ANY: return who;
      EVT_DATA_RCV: return self_m && e.data_rcv;
      EVT_BNR_DRV: return self_m && e.bnr_drv;
      EVT_HIT_DRV: return self_m && e.hit_drv;
      EVT_SNOOP_HIT_MODIFIED_N_DRV: return self_m && e.snoop_hit_modified_n_drv;
      default: return 1'b0;
    endcase
  endfunction
  task automatic cmp_cnt(string name, logic [W-1:0] exp, logic [W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_bit(string name, logic exp, logic got);
    cmp_cnt(name, W'(exp), W'(got));
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Model is stepped from the values the design sampled at the same edge
  task automatic step();
    bepc_sel_t s;
    bepc_bus_evt_t e;
    logic inc, en, clr, gate;
    logic [1:0] r;
    @(posedge i_clk_sys);
    s = i_sel;
    e = i_bus_evt;
    en = i_bus_clk_en;
    clr = i_count_clear;
    r = i_clk_ratio;
    #1;
    inc = en && s.enable && !clr && qual(s, e);
    gate = (s.evt_code === EVT_HIT_DRV || s.evt_code === EVT_SNOOP_HIT_MODIFIED_N_DRV) && r < 2'h2;
    exp_pins = (exp_ovf && !gate) ^ (!s.pin_control_bit && exp_pins);
    exp_ovf = inc && &exp_cnt;
    exp_cnt = clr ? '0 : exp_cnt + W'(inc);
    cmp_cnt("o_count", exp_cnt, o_count);
    cmp_bit("o_overflow", exp_ovf, o_overflow);
    cmp_bit("o_breakpoint_monitor_pins", exp_pins, o_pins);
    i_sel.enable = ($urandom % 8) != 0;
    i_count_clear = ($urandom % 64) == 0;
  endtask
  initial begin
    void'($urandom(61387));
    repeat (3) @(posedge i_clk_sys);
    #1;
    // Each entry restarts from reset so a toggled pin level never leaks across
    for (int i = 0; i < 12; i++) begin
      i_rst = 1'b1;
      i_clk_ratio = (i == 8) ? 2'h3 : (i == 9) ? 2'h1 : 2'($urandom);
      i_sel = '{evt_code: codes[i], unit_mask: masks[i], pin_control_bit: (i == 8) | 1'($urandom), enable: 1'b1};
      @(posedge i_clk_sys);
      #1;
      i_rst = 1'b0;
      {exp_cnt, exp_ovf, exp_pins} = '0;
      repeat (200) step();
    end
    conclude();
  end
  initial begin
    #60000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
